/* File: core/gated_sixteen_bit_timer.sv */
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
module gated_sixteen_bit_timer (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire tmr_pkg::reg_req_t bus_req,
    output logic [tmr_pkg::DATA_W-1:0] rd_data,
    input wire logic ext_count_input,
    input wire logic gate_pin,
    input wire logic cmp1_out,
    input wire logic cmp2_out,
    input wire logic low_freq_internal_osc,
    input wire logic crystal_in_pin,
    input wire logic sleep_mode,
    output logic crystal_out_pin,
    output logic overflow_flag,
    output logic [tmr_pkg::COUNT_W-1:0] count_value
);
    import tmr_pkg::*;

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic [DATA_W-1:0] ctrl;
        logic [DATA_W-1:0] gate;
        logic ovf;
        logic [PS_W-1:0] pre_cnt;
        logic [1:0] phase;
        logic pend;
        edge_arm_t arm;
        logic [DATA_W-1:0] rdata;
        logic xout;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    logic [PIN_N-1:0] pin_async;
    logic [PIN_N-1:0] pin_lvl;
    logic [PIN_N-1:0] pin_rise;
    logic [PIN_N-1:0] pin_fall;

    logic run;
    logic no_sync;
    logic osc_en;
    logic [1:0] cs;
    logic [1:0] ps;
    logic gate_en;
    logic gate_pol;
    logic [1:0] gate_src;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic wr_gate;
    logic wr_status;
    logic count_wr;
    logic ext_sel;
    logic ext_rise;
    logic ext_fall;
    logic ext_tick;
    logic phase_end;
    logic armed;
    logic gate_lvl;
    logic gate_ok;
    logic awake_ok;
    logic raw_tick;
    logic count_en;
    logic inc;
    logic ovf_clear;

    function automatic logic hit(input reg_req_t req, input logic [ADDR_W-1:0] addr);
        return req.addr == addr;
    endfunction : hit

    function automatic logic [PS_W-1:0] ps_last(input logic [1:0] sel);
        return PS_W'((1 << sel) - 1);
    endfunction : ps_last

    assign pin_async = {crystal_in_pin, low_freq_internal_osc, cmp2_out, cmp1_out, gate_pin, ext_count_input};

    // Every pin crosses two flops before any logic reads it.
    pin_sync #(
        .WIDTH(PIN_N)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in(pin_async),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign run = state_r.ctrl[CTRL_RUN_BIT];
    assign no_sync = state_r.ctrl[CTRL_NOSYNC_BIT];
    assign osc_en = state_r.ctrl[CTRL_OSC_EN_BIT];
    assign cs = state_r.ctrl[CTRL_CS_LSB +: 2];
    assign ps = state_r.ctrl[CTRL_PS_LSB +: 2];
    assign gate_en = state_r.gate[GATE_EN_BIT];
    assign gate_pol = state_r.gate[GATE_POL_BIT];
    assign gate_src = state_r.gate[GATE_SRC_LSB +: 2];

    assign wr_low = bus_req.wr && hit(bus_req, ADDR_COUNT_LOW);
    assign wr_high = bus_req.wr && hit(bus_req, ADDR_COUNT_HIGH);
    assign wr_ctrl = bus_req.wr && hit(bus_req, ADDR_CTRL);
    assign wr_gate = bus_req.wr && hit(bus_req, ADDR_GATE);
    assign wr_status = bus_req.wr && hit(bus_req, ADDR_STATUS);
    assign count_wr = wr_low || wr_high;
    assign ovf_clear = wr_status && bus_req.wdata[STAT_OVF_BIT];

    // With the oscillator on, select code 10 takes the crystal instead of the input pin.
    assign ext_sel = cs == CS_EXT;
    assign ext_rise = osc_en ? pin_rise[PIN_XTAL] : pin_rise[PIN_EXT];
    assign ext_fall = osc_en ? pin_fall[PIN_XTAL] : pin_fall[PIN_EXT];
    assign phase_end = state_r.phase == PHASE_LAST;

    // Synchronous mode holds an edge until the instruction boundary; no-sync passes it at once.
    assign ext_tick = no_sync ? ext_rise : (state_r.pend && phase_end);
    assign armed = state_r.arm == ARM_READY;

    assign gate_lvl = (gate_src == GSRC_CMP1) ? pin_lvl[PIN_CMP1] :
                      (gate_src == GSRC_CMP2) ? pin_lvl[PIN_CMP2] : pin_lvl[PIN_GATE];
    assign gate_ok = !gate_en || (gate_lvl == gate_pol);

    // In sleep only the asynchronous external source keeps counting.
    assign awake_ok = !sleep_mode || (ext_sel && no_sync);

    always_comb begin
        unique case (cs)
            CS_INSTR: raw_tick = phase_end;
            CS_SYS: raw_tick = 1'b1;
            CS_EXT: raw_tick = ext_tick && armed;
            CS_LFOSC: raw_tick = pin_rise[PIN_LFOSC];
        endcase
    end

    assign count_en = run && gate_ok && awake_ok && raw_tick;
    assign inc = count_en && (state_r.pre_cnt == ps_last(ps));

    always_comb begin
        state_nxt = state_r;
        state_nxt.phase = 2'(state_r.phase + 2'h1);

        // A switch to no-sync drops a waiting edge; a switch back to synchronous mode starts with none pending.
        if (no_sync) begin
            state_nxt.pend = 1'b0;
        end else begin
            if (state_r.pend && phase_end) begin
                state_nxt.pend = 1'b0;
            end
            if (ext_rise) begin
                state_nxt.pend = 1'b1;
            end
        end

        if (count_wr || !run) begin
            state_nxt.arm = ARM_WAIT_FALL;
        end else if (ext_fall) begin
            state_nxt.arm = ARM_READY;
        end

        // A control write restarts the prescaler as well, so a smaller ratio never inherits a stale count.
        if (count_wr || wr_ctrl) begin
            state_nxt.pre_cnt = '0;
        end else if (count_en) begin
            state_nxt.pre_cnt = inc ? '0 : PS_W'(state_r.pre_cnt + 1'b1);
        end

        if (inc) begin
            state_nxt.count = COUNT_W'(state_r.count + 1'b1);
        end
        // A write wins over a coincident increment for the written byte.
        if (wr_low) begin
            state_nxt.count[DATA_W-1:0] = bus_req.wdata;
        end
        if (wr_high) begin
            state_nxt.count[COUNT_W-1:DATA_W] = bus_req.wdata;
        end

        if (ovf_clear) begin
            state_nxt.ovf = 1'b0;
        end
        // A roll-over in the clearing cycle still sets the flag.
        if (inc && (state_r.count == COUNT_ALL_ONES)) begin
            state_nxt.ovf = 1'b1;
        end

        if (wr_ctrl) begin
            state_nxt.ctrl = bus_req.wdata;
        end
        if (wr_gate) begin
            state_nxt.gate = bus_req.wdata;
        end

        // Reads come from the registered count, so each byte is a settled value.
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                ADDR_COUNT_LOW: state_nxt.rdata = state_r.count[DATA_W-1:0];
                ADDR_COUNT_HIGH: state_nxt.rdata = state_r.count[COUNT_W-1:DATA_W];
                ADDR_CTRL: state_nxt.rdata = state_r.ctrl;
                ADDR_GATE: state_nxt.rdata = state_r.gate;
                ADDR_STATUS: state_nxt.rdata = {{(DATA_W-1){1'b0}}, state_r.ovf};
                default: state_nxt.rdata = '0;
            endcase
        end else begin
            state_nxt.rdata = '0;
        end

        // The amplifier drives the crystal only while enabled, independent of sleep.
        state_nxt.xout = osc_en && !pin_lvl[PIN_XTAL];
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r.count <= COUNT_RESET;
            state_r.ctrl <= CTRL_RESET;
            state_r.gate <= GATE_RESET;
            state_r.ovf <= 1'b0;
            state_r.pre_cnt <= '0;
            state_r.phase <= 2'h0;
            state_r.pend <= 1'b0;
            state_r.arm <= ARM_WAIT_FALL;
            state_r.rdata <= '0;
            state_r.xout <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rd_data = state_r.rdata;
    assign crystal_out_pin = state_r.xout;
    assign overflow_flag = state_r.ovf;
    assign count_value = state_r.count;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    property p_write_low;
        wr_low |=> state_r.count[DATA_W-1:0] == $past(bus_req.wdata[DATA_W-1:0]);
    endproperty
    a_write_low: assert property (p_write_low) else $error("Low byte write not applied.");

    property p_write_high;
        wr_high |=> state_r.count[COUNT_W-1:DATA_W] == $past(bus_req.wdata[DATA_W-1:0]);
    endproperty
    a_write_high: assert property (p_write_high) else $error("High byte write not applied.");

    property p_run_off;
        (!run && !count_wr) |=> state_r.count == $past(state_r.count);
    endproperty
    a_run_off: assert property (p_run_off) else $error("Count moved while stopped.");

    sequence s_free_sys;
        (run && !gate_en && !sleep_mode && cs == CS_SYS && ps == 2'h0 && !count_wr && !wr_ctrl && !wr_gate);
    endsequence

    property p_four_per_instr;
        s_free_sys [*4] |=> state_r.count == COUNT_W'($past(state_r.count, 4) + 16'h0004);
    endproperty
    a_four_per_instr: assert property (p_four_per_instr) else $error("System clock did not add four.");

    property p_instr_tick;
        (run && !gate_en && !sleep_mode && cs == CS_INSTR && ps == 2'h0 && !count_wr && !phase_end)
            |=> state_r.count == $past(state_r.count);
    endproperty
    a_instr_tick: assert property (p_instr_tick) else $error("Instruction clock counted off boundary.");

    property p_prescale_clear;
        count_wr |=> state_r.pre_cnt == '0;
    endproperty
    a_prescale_clear: assert property (p_prescale_clear) else $error("Prescaler not cleared.");

    property p_prescale_range;
        state_r.pre_cnt <= ps_last(ps);
    endproperty
    a_prescale_range: assert property (p_prescale_range) else $error("Prescaler out of range.");

    property p_arm_clear;
        (count_wr || !run) |=> state_r.arm == ARM_WAIT_FALL;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("Edge arm not cleared.");

    property p_unarmed_hold;
        (ext_sel && !armed && !count_wr) |=> state_r.count == $past(state_r.count);
    endproperty
    a_unarmed_hold: assert property (p_unarmed_hold) else $error("Counted before falling edge.");

    property p_gate_hold;
        (gate_en && gate_lvl != gate_pol && !count_wr) |=> state_r.count == $past(state_r.count);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("Counted with gate closed.");

    property p_gate_open;
        (run && gate_en && gate_lvl == gate_pol && !sleep_mode && cs == CS_SYS && ps == 2'h0 && !count_wr)
            |=> state_r.count == COUNT_W'($past(state_r.count) + 16'h0001);
    endproperty
    a_gate_open: assert property (p_gate_open) else $error("Count held with gate open.");

    property p_sleep_stop;
        (sleep_mode && !(ext_sel && no_sync) && !count_wr) |=> state_r.count == $past(state_r.count);
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("Counted in sleep.");

    property p_async_edge;
        (run && !gate_en && ext_sel && no_sync && armed && ps == 2'h0 && ext_rise && !count_wr)
            |=> state_r.count == COUNT_W'($past(state_r.count) + 16'h0001);
    endproperty
    a_async_edge: assert property (p_async_edge) else $error("Async edge not counted.");

    sequence s_rollover;
        inc && state_r.count == COUNT_ALL_ONES;
    endsequence

    property p_ovf_set;
        s_rollover |=> overflow_flag && (state_r.count == COUNT_RESET || $past(count_wr));
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("Overflow flag not set.");

    property p_ovf_sticky;
        (overflow_flag && !ovf_clear) |=> overflow_flag;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("Overflow flag lost.");

    property p_read_low;
        (bus_req.rd && hit(bus_req, ADDR_COUNT_LOW)) |=> rd_data == $past(state_r.count[DATA_W-1:0]);
    endproperty
    a_read_low: assert property (p_read_low) else $error("Low byte read wrong.");

    property p_osc_off;
        !osc_en |=> !crystal_out_pin;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("Oscillator driven while off.");

endmodule : gated_sixteen_bit_timer

/* File: core/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] prev;
    } sync_state_t;

    sync_state_t state_r;
    sync_state_t state_nxt;

    // Only the second stage feeds the edge detector; the first stage is never read elsewhere.
    always_comb begin
        state_nxt.meta = async_in;
        state_nxt.stable = state_r.meta;
        state_nxt.prev = state_r.stable;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign level = state_r.stable;
    assign rise = state_r.stable & ~state_r.prev;
    assign fall = ~state_r.stable & state_r.prev;

endmodule : pin_sync

/* File: core/tmr_pkg.sv */
package tmr_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int COUNT_W = 16;
    localparam int PS_W = 3;

    // Register offsets on the plain register port.
    localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_GATE = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h4;

    // Field positions of the control, gate and status registers.
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_NOSYNC_BIT = 2;
    localparam int CTRL_OSC_EN_BIT = 3;
    localparam int CTRL_PS_LSB = 4;
    localparam int CTRL_CS_LSB = 6;
    localparam int GATE_SRC_LSB = 0;
    localparam int GATE_POL_BIT = 6;
    localparam int GATE_EN_BIT = 7;
    localparam int STAT_OVF_BIT = 0;

    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] GATE_RESET = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ALL_ONES = 16'hFFFF;

    // Clock select codes.
    localparam logic [1:0] CS_INSTR = 2'h0;
    localparam logic [1:0] CS_SYS = 2'h1;
    localparam logic [1:0] CS_EXT = 2'h2;
    localparam logic [1:0] CS_LFOSC = 2'h3;

    // Gate source codes.
    localparam logic [1:0] GSRC_PIN = 2'h0;
    localparam logic [1:0] GSRC_CMP1 = 2'h1;
    localparam logic [1:0] GSRC_CMP2 = 2'h2;

    // One instruction cycle spans four system clocks; the phase counter wraps here.
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // Bit positions in the vector of synchronised pins.
    localparam int PIN_EXT = 0;
    localparam int PIN_GATE = 1;
    localparam int PIN_CMP1 = 2;
    localparam int PIN_CMP2 = 3;
    localparam int PIN_LFOSC = 4;
    localparam int PIN_XTAL = 5;
    localparam int PIN_N = 6;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef enum logic [0:0] {
        ARM_WAIT_FALL = 1'b0,
        ARM_READY = 1'b1
    } edge_arm_t;

endpackage : tmr_pkg

/* File: tb/ext_clock_model.sv */
`timescale 1ns/1ps
module ext_clock_model (
    input wire logic sys_clk,
    input wire logic xtal_run,
    output logic ext_count_input,
    output logic crystal_in_pin
);
    logic [2:0] half_cnt;

    initial begin
        ext_count_input = 1'b0;
        crystal_in_pin = 1'b0;
        half_cnt = 3'h0;
    end

    // Each pulse rises, holds six cycles, falls and holds six more; the line then stands low.
    task pulses(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            ext_count_input <= 1'b1;
            repeat (6) @(posedge sys_clk);
            ext_count_input <= 1'b0;
            repeat (6) @(posedge sys_clk);
        end
    endtask : pulses

    // The crystal is scaled to a ten-cycle period and keeps swinging while enabled, also in sleep.
    always @(posedge sys_clk) begin
        if (xtal_run) begin
            half_cnt <= (half_cnt == 3'h4) ? 3'h0 : half_cnt + 3'h1;
            if (half_cnt == 3'h4) begin
                crystal_in_pin <= ~crystal_in_pin;
            end
        end else begin
            half_cnt <= 3'h0;
            crystal_in_pin <= 1'b0;
        end
    end
endmodule : ext_clock_model

/* File: tb/gated_sixteen_bit_timer_bench.sv */
`timescale 1ns/1ps
module gated_sixteen_bit_timer_bench;
    import tmr_pkg::*;
    logic sys_clk, nrst, gate_pin, cmp1_out, cmp2_out, low_freq_internal_osc, sleep_mode, xtal_run;
    logic ext_count_input, crystal_in_pin, crystal_out_pin, overflow_flag;
    reg_req_t bus_req;
    logic [DATA_W-1:0] rd_data, d;
    logic [COUNT_W-1:0] count_value, live, dlt;
    int n_fail, checks_done, cycles;

    gated_sixteen_bit_timer i_dut (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req), .rd_data(rd_data),
        .ext_count_input(ext_count_input), .gate_pin(gate_pin), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
        .low_freq_internal_osc(low_freq_internal_osc), .crystal_in_pin(crystal_in_pin),
        .sleep_mode(sleep_mode), .crystal_out_pin(crystal_out_pin), .overflow_flag(overflow_flag),
        .count_value(count_value));
    ext_clock_model i_src (.sys_clk(sys_clk), .xtal_run(xtal_run), .ext_count_input(ext_count_input),
        .crystal_in_pin(crystal_in_pin));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // The slow oscillator is an eight-cycle square wave with edges on falling clock edges, away from the rising ones.
    initial begin
        low_freq_internal_osc = 1'b0;
        forever #20 low_freq_internal_osc = ~low_freq_internal_osc;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail++;
            end_of_test();
        end
    end

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // The live count is captured in the cycle the read is taken, for comparing with the returned byte.
    task rd(input logic [ADDR_W-1:0] a);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        #1 live = count_value;
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 d = rd_data;
    endtask : rd

    task ctrl(input logic [1:0] cs, input logic [1:0] ps, input logic osc, input logic nosync, input logic run);
        wr(ADDR_CTRL, {cs, ps, osc, nosync, 1'b0, run});
    endtask : ctrl

    task measure(input int n);
        @(posedge sys_clk);
        #1 live = count_value;
        repeat (n) @(posedge sys_clk);
        #1 dlt = count_value - live;
    endtask : measure

    task t_reset_and_write;
        for (int a = 0; a < 8; a++) begin
            rd(a[ADDR_W-1:0]);
            check("reset or unmapped read", {8'h00, d}, 16'h0000);
        end
        check("amplifier off after reset", {15'h0000, crystal_out_pin}, 16'h0000);
        wr(ADDR_COUNT_LOW, 8'hA5);
        wr(ADDR_COUNT_HIGH, 8'h3C);
        #1;
        check("written count", count_value, 16'h3CA5);
        ctrl(CS_SYS, 2'h0, 1'b0, 1'b0, 1'b0);
        measure(64);
        check("count while off", dlt, 16'h0000);
    endtask : t_reset_and_write

    task t_sources;
        for (int p = 0; p < 4; p++) begin
            ctrl(CS_SYS, p[1:0], 1'b0, 1'b0, 1'b1);
            repeat (20) @(posedge sys_clk);
            measure(64);
            check("prescaled system clock", dlt, 16'(64 >> p));
        end
        ctrl(CS_INSTR, 2'h0, 1'b0, 1'b0, 1'b1);
        measure(64);
        check("instruction clock", dlt, 16'h0010);
        ctrl(CS_LFOSC, 2'h0, 1'b0, 1'b0, 1'b1);
        measure(64);
        check("slow oscillator", dlt, 16'h0008);
        ctrl(CS_SYS, 2'h0, 1'b0, 1'b0, 1'b1);
        rd(ADDR_COUNT_LOW);
        check("low byte while running", {8'h00, d}, {8'h00, live[7:0]});
        rd(ADDR_COUNT_HIGH);
        check("high byte while running", {8'h00, d}, {8'h00, live[15:8]});
    endtask : t_sources

    task t_gate;
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < 4; k++) begin
                wr(ADDR_GATE, {1'b1, k[1], 4'h0, s[1:0]});
                gate_pin <= (s == 0) ? k[0] : ~k[0];
                cmp1_out <= (s == 1) ? k[0] : ~k[0];
                cmp2_out <= (s == 2) ? k[0] : ~k[0];
                repeat (8) @(posedge sys_clk);
                measure(32);
                check("gated count", dlt, (k[0] == k[1]) ? 16'h0020 : 16'h0000);
            end
        end
        wr(ADDR_GATE, 8'h40);
        measure(32);
        check("free running with gate off", dlt, 16'h0020);
    endtask : t_gate

    task t_external;
        ctrl(CS_EXT, 2'h0, 1'b0, 1'b1, 1'b0);
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h00);
        ctrl(CS_EXT, 2'h0, 1'b0, 1'b1, 1'b1);
        i_src.pulses(5);
        repeat (8) @(posedge sys_clk);
        check("first rise needs a fall", count_value, 16'h0004);
        ctrl(CS_EXT, 2'h0, 1'b0, 1'b0, 1'b1);
        i_src.pulses(5);
        repeat (8) @(posedge sys_clk);
        check("synchronised edges", count_value, 16'h0009);
        sleep_mode <= 1'b1;
        i_src.pulses(3);
        repeat (8) @(posedge sys_clk);
        check("synchronised in sleep", count_value, 16'h0009);
        ctrl(CS_EXT, 2'h0, 1'b0, 1'b1, 1'b1);
        i_src.pulses(3);
        repeat (8) @(posedge sys_clk);
        check("asynchronous in sleep", count_value, 16'h000C);
        ctrl(CS_SYS, 2'h0, 1'b0, 1'b0, 1'b1);
        measure(32);
        check("system clock in sleep", dlt, 16'h0000);
        sleep_mode <= 1'b0;
    endtask : t_external

    task t_crystal;
        ctrl(CS_EXT, 2'h0, 1'b1, 1'b1, 1'b0);
        wr(ADDR_STATUS, 8'h01);
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'hFC);
        ctrl(CS_EXT, 2'h0, 1'b1, 1'b1, 1'b1);
        sleep_mode <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check("crystal amplifier drive", {15'h0000, crystal_out_pin}, 16'h0001);
        xtal_run <= 1'b1;
        for (int i = 0; i < 12000 && overflow_flag !== 1'b1; i++) begin
            @(posedge sys_clk);
        end
        check("overflow after start-up count", {15'h0000, overflow_flag}, 16'h0001);
        check("count wrapped", {15'h0000, count_value < 16'h0010}, 16'h0001);
        xtal_run <= 1'b0;
        sleep_mode <= 1'b0;
        ctrl(CS_EXT, 2'h0, 1'b1, 1'b1, 1'b0);
        repeat (20) @(posedge sys_clk);
        rd(ADDR_STATUS);
        check("sticky overflow", {8'h00, d}, 16'h0001);
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS);
        check("overflow cleared", {8'h00, d}, 16'h0000);
    endtask : t_crystal

    initial begin
        nrst = 1'b0;
        bus_req = '0;
        gate_pin = 1'b0;
        cmp1_out = 1'b0;
        cmp2_out = 1'b0;
        sleep_mode = 1'b0;
        xtal_run = 1'b0;
        n_fail = 0;
        checks_done = 0;
        cycles = 0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset_and_write();
        t_sources();
        t_gate();
        t_external();
        t_crystal();
        end_of_test();
    end
endmodule : gated_sixteen_bit_timer_bench
